// *** dv/cfg_host_port_asserts.sv ***
// Port checker for the configuration and host port block
`timescale 1ns/1ps
module cfg_host_port_asserts
   import cfg_host_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  rst_b,
   input wire logic                  setup_wait_in,
   input wire logic                  setup_wait_out,
   input wire logic                  setup_wait_oe,
   input wire logic [3:0]            mode_sel,
   input wire logic                  chip_select_low_n,
   input wire logic                  chip_select_high,
   input wire logic                  host_read_not_write,
   input wire logic [1:0]            host_transfer_size,
   input wire logic                  status_oe,
   input wire logic                  host_transfer_ack,
   input wire logic [BYTES_W-1:0]    host_bytes,
   input wire logic [MEM_ADDR_W-1:0] cfg_mem_addr,
   input wire logic                  cfg_mem_rd_n,
   input wire logic                  cfg_busy_high_flag,
   input wire logic                  cfg_busy_low_flag,
   input wire logic [3:0]            mode_latched,
   input wire logic                  cfg_byte_valid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   function automatic logic [BYTES_W-1:0] size_bytes(logic [1:0] s);
      case (s)
         2'h1: return 3'h1;
         2'h2: return 3'h2;
         2'h0: return 3'h4;
         default: return 3'h0;
      endcase
   endfunction

   busy_reset_a: assert property ($past(!rst_b) |-> cfg_busy_high_flag && !cfg_busy_low_flag)
      else $error("busy flags wrong after reset");
   setup_low_a: assert property ($past(!rst_b) |-> setup_wait_oe && !setup_wait_out)
      else $error("setup-wait not pulled low");
   select_only_a: assert property ($rose(status_oe) |->
      !$past(chip_select_low_n) && $past(chip_select_high))
      else $error("status driven while unselected");
   write_wins_a: assert property (status_oe |-> $past(host_read_not_write, 2))
      else $error("status driven during write");
   ack_pulse_a: assert property ($fell(host_transfer_ack) |=> host_transfer_ack)
      else $error("ack longer than one cycle");
   mem_step_a: assert property (!cfg_mem_rd_n |=>
      cfg_mem_rd_n && cfg_mem_addr == $past(cfg_mem_addr) + 22'h1)
      else $error("memory address did not step");
   size_decode_a: assert property ($changed(host_bytes) |->
      host_bytes == size_bytes($past(host_transfer_size)))
      else $error("size decoded wrongly");
   mode_capture_a: assert property ($changed(mode_latched) |-> $past(setup_wait_in) &&
      !$past(setup_wait_in, 2) && mode_latched == $past(mode_sel))
      else $error("mode captured off the rising edge");

   cover property ($fell(host_transfer_ack));
   cover property (!cfg_mem_rd_n);
   cover property ($rose(status_oe));
   cover property ($rose(cfg_byte_valid));
endmodule

// *** dv/cfg_mem_model.sv ***
// External configuration memory on the parallel address port
`timescale 1ns/1ps
module cfg_mem_model
   import cfg_host_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic [MEM_ADDR_W-1:0] addr,
   input  wire logic                  rd_n,
   output logic      [DATA_W-1:0]     data
);
   initial data = 8'h00;
   // Byte stands from just after the read pulse starts through the capture edge
   always @(posedge clk) begin
      #2;
      if (!rd_n) begin
         data = addr[7:0] ^ 8'h5A;
      end else begin
         data = ~data;
      end
   end
endmodule

// *** dv/config_and_host_port_pins_bench.sv ***
// Self-checking bench for the configuration and host port block
`timescale 1ns/1ps
module config_and_host_port_pins_bench;
   import cfg_host_pkg::*;
   logic       clk = 1'b0, rst_b = 1'b0, mem_clear_done = 1'b0, cfg_complete = 1'b0;
   logic       hold_low = 1'b0, cs_n = 1'b1, cs = 1'b0, rd_stb = 1'b1, rw = 1'b1;
   logic       burst_n = 1'b1, beat = 1'b0, cfg_byte_ready = 1'b0, use_mem = 1'b0;
   logic [3:0] mode_sel = 4'h0, usr = 4'h0, mode_q;
   logic [1:0] size = 2'h0;
   logic [7:0] bus_d = 8'h00, byte_data, mem_data;
   logic [HOST_ADDR_W-1:0] addr = 18'h00000, addr_seen;
   logic [STAT_W-1:0]      stat;
   logic [BYTES_W-1:0]     nbytes;
   logic [MEM_ADDR_W-1:0]  mem_addr;
   logic swo, swoe, stat_oe, ready_status, ack, rd_n, busy_h, busy_l, byte_valid;
   int   num_errors = 0, num_checks = 0, cycles = 0;
   localparam logic [2:0] SZ_BYTES [4] = '{3'h4, 3'h1, 3'h2, 3'h0};
   // Open-drain wire with pull-up
   wire       setup_wait = (hold_low || (swoe && !swo)) ? 1'b0 : 1'b1;
   wire [7:0] data_in = use_mem ? mem_data : bus_d;

   cfg_host_port dut (.clk(clk), .rst_b(rst_b), .mem_clear_done(mem_clear_done),
      .cfg_complete(cfg_complete), .setup_wait_in(setup_wait), .setup_wait_out(swo),
      .setup_wait_oe(swoe), .mode_sel(mode_sel), .chip_select_low_n(cs_n),
      .chip_select_high(cs), .host_transfer_strobe(rd_stb), .host_read_not_write(rw),
      .data_in(data_in), .status_out(stat), .status_oe(stat_oe), .ready_status(ready_status),
      .host_address_bus(addr), .host_burst_n(burst_n), .host_beat_in_progress(beat),
      .host_transfer_size(size), .host_transfer_ack(ack), .host_addr_latched(addr_seen),
      .host_bytes(nbytes), .cfg_mem_addr(mem_addr), .cfg_mem_rd_n(rd_n),
      .cfg_busy_high_flag(busy_h), .cfg_busy_low_flag(busy_l), .user_busy_high(usr[3]),
      .user_busy_low(usr[2]), .user_setup_wait_out(usr[1]), .user_setup_wait_oe(usr[0]),
      .mode_latched(mode_q), .cfg_byte_valid(byte_valid), .cfg_byte_data(byte_data),
      .cfg_byte_ready(cfg_byte_ready));
   cfg_mem_model mem (.clk(clk), .addr(mem_addr), .rd_n(rd_n), .data(mem_data));

   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic check_val(logic [31:0] got, logic [31:0] exp, string what);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Reset, clear memory, then hold setup-wait low from outside
   task automatic boot(logic [3:0] m);
      rst_b = 1'b0;
      mem_clear_done = 1'b0;
      cfg_complete = 1'b0;
      mode_sel = m;
      tick(3);
      rst_b = 1'b1;
      tick(2);
      check_val(setup_wait, 1'b0, "wait low in clear");
      check_val({busy_h, busy_l}, 2'b10, "busy in clear");
      hold_low = 1'b1;
      mem_clear_done = 1'b1;
      tick(4);
      check_val(swoe, 1'b0, "wait released by device");
   endtask
   task automatic release_wait(logic [3:0] m);
      hold_low = 1'b0;
      tick(2);
      mode_sel = ~m;
      tick(2);
      check_val(mode_q, m, "mode captured");
      check_val({busy_h, busy_l}, 2'b10, "busy in load");
   endtask
   task automatic wr_async(logic [7:0] d);
      bus_d = d;
      rw = 1'b0;
      tick(3);
      rw = 1'b1;
      tick(2);
   endtask
   task automatic host_xfer(logic r, logic b_n, logic early, output int acks);
      acks = 0;
      rw = r;
      burst_n = b_n;
      beat = !b_n;
      rd_stb = 1'b0;
      tick(1);
      rd_stb = 1'b1;
      repeat (24) begin
         tick(1);
         if (ack === 1'b0) begin
            acks++;
            if (r) begin
               check_val(stat_oe, 1'b1, "read data driven");
            end
            if (early) begin
               beat = 1'b0;
            end
         end
      end
      burst_n = 1'b1;
      beat = 1'b0;
      rw = 1'b1;
   endtask

   task automatic test_async();
      logic [7:0] exp_b;
      boot(MODE_ASYNC_PERIPH);
      cs_n = 1'b0;
      cs = 1'b1;
      wr_async(8'h11);
      check_val(byte_valid, 1'b0, "write held off in wait");
      release_wait(MODE_ASYNC_PERIPH);
      cs = 1'b0;
      wr_async(8'h22);
      cs = 1'b1;
      check_val(byte_valid, 1'b0, "unselected write");
      for (int i = 0; i < 4; i++) begin
         wr_async(8'hA0 + 8'(i));
      end
      check_val(ready_status, 1'b0, "busy when full");
      rd_stb = 1'b0;
      tick(3);
      check_val(stat_oe, 1'b1, "status driven");
      check_val(stat, 5'h0E, "status shows busy");
      bus_d = 8'hE7;
      rw = 1'b0;
      tick(3);
      check_val(stat_oe, 1'b0, "write overrides read");
      rd_stb = 1'b1;
      rw = 1'b1;
      cfg_byte_ready = 1'b1;
      for (int i = 0; i < 5; i++) begin
         exp_b = (i < 4) ? 8'hA0 + 8'(i) : 8'hE7;
         check_val({byte_valid, byte_data}, {1'b1, exp_b}, "async byte");
         tick(1);
      end
      check_val({byte_valid, ready_status}, 2'b01, "drained and ready");
      $display("test async done");
   endtask

   task automatic test_proc();
      int n;
      boot(MODE_PROC);
      release_wait(MODE_PROC);
      bus_d = 8'h3C;
      cfg_byte_ready = 1'b0;
      for (int i = 0; i < 4; i++) begin
         size = 2'(i);
         addr = 18'h2A5C3 + 18'(i);
         host_xfer(1'b0, 1'b1, 1'b0, n);
         check_val(n, 1, "single write ack");
         check_val(nbytes, SZ_BYTES[i], "size decode");
         check_val(addr_seen, addr, "address latched");
         if (i == 0) begin
            check_val({byte_valid, byte_data}, {1'b1, 8'h3C}, "host write byte");
            cfg_byte_ready = 1'b1;
         end
      end
      host_xfer(1'b1, 1'b1, 1'b0, n);
      check_val(n, 1, "single read ack");
      host_xfer(1'b0, 1'b0, 1'b0, n);
      check_val(n, 4, "full burst beats");
      host_xfer(1'b0, 1'b0, 1'b1, n);
      check_val(n, 1, "burst aborted");
      $display("test processor done");
   endtask

   task automatic test_master_done();
      use_mem = 1'b1;
      cfg_byte_ready = 1'b0;
      boot(MODE_MASTER_PAR);
      release_wait(MODE_MASTER_PAR);
      tick(20);
      cfg_byte_ready = 1'b1;
      for (int i = 0; i < 3; i++) begin
         check_val({byte_valid, byte_data}, {1'b1, 8'(i) ^ 8'h5A}, "memory byte");
         tick(1);
      end
      cfg_complete = 1'b1;
      usr = 4'h6;
      tick(4);
      check_val({busy_h, busy_l, swoe}, 3'b010, "user pins after done");
      usr = 4'h9;
      tick(2);
      check_val({busy_h, busy_l, swoe, stat_oe}, 4'hA, "user pins follow");
      $display("test master and done finished");
   endtask

   initial begin
      test_async();
      test_proc();
      test_master_done();
      final_report();
   end
endmodule

bind cfg_host_port cfg_host_port_asserts chk (.clk, .rst_b, .setup_wait_in, .setup_wait_out,
   .setup_wait_oe, .mode_sel, .chip_select_low_n, .chip_select_high, .host_read_not_write,
   .host_transfer_size, .status_oe, .host_transfer_ack, .host_bytes, .cfg_mem_addr,
   .cfg_mem_rd_n, .cfg_busy_high_flag, .cfg_busy_low_flag, .mode_latched, .cfg_byte_valid);

// *** include/cfg_host_pkg.sv ***
// Shared constants and types for the configuration and host port block
package cfg_host_pkg;
   localparam int DATA_W      = 8;
   localparam int MEM_ADDR_W  = 22;
   localparam int HOST_ADDR_W = 18;
   localparam int STAT_W      = 5;
   localparam int FIFO_DEPTH  = 4;
   localparam int BYTES_W     = 3;
   localparam int BEAT_W      = 2;

   // Configuration mode codes on the mode select inputs
   localparam logic [3:0] MODE_ASYNC_PERIPH = 4'h5;
   localparam logic [3:0] MODE_SLAVE_PAR    = 4'h7;
   localparam logic [3:0] MODE_PROC         = 4'h3;
   localparam logic [3:0] MODE_MASTER_PAR   = 4'h2;

   // Host transfer size codes and their byte counts
   localparam logic [1:0] TSZ_BYTE  = 2'h1;
   localparam logic [1:0] TSZ_HALF  = 2'h2;
   localparam logic [1:0] TSZ_WORD  = 2'h0;
   localparam logic [BYTES_W-1:0] BYTES_ONE  = 3'h1;
   localparam logic [BYTES_W-1:0] BYTES_TWO  = 3'h2;
   localparam logic [BYTES_W-1:0] BYTES_FOUR = 3'h4;
   localparam logic [BYTES_W-1:0] BYTES_NONE = 3'h0;

   // Index of the last beat in a full four-beat host burst
   localparam logic [BEAT_W-1:0] BURST_LAST_BEAT = 2'h3;

   // External memory address range, four megabytes
   localparam logic [MEM_ADDR_W-1:0] MEM_ADDR_FIRST = 22'h000000;
   localparam logic [MEM_ADDR_W-1:0] MEM_ADDR_LAST  = 22'h3FFFFF;

   // Status field driven on data lines 7 down to 3
   localparam int STAT_READY_BIT = 4;
   localparam int STAT_LOAD_BIT  = 3;
   localparam int STAT_FULL_BIT  = 2;
   localparam int STAT_SEL_BIT   = 1;
   localparam int STAT_BURST_BIT = 0;

   typedef enum logic [1:0] {
      ST_CLEAR,
      ST_WAIT,
      ST_LOAD,
      ST_DONE
   } cfg_state_t;
endpackage

// *** src/byte_fifo.sv ***
// Small FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [PW:0]                 count;
   } fifo_t;

   fifo_t f_q;
   fifo_t f_d;
   logic  push;
   logic  pop;

   assign in_ready  = (f_q.count != DEPTH[PW:0]);
   assign out_valid = (f_q.count != '0);
   assign out_data  = f_q.mem[f_q.rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      f_d = f_q;
      if (push) begin
         f_d.mem[f_q.wr_ptr] = in_data;
         f_d.wr_ptr = (f_q.wr_ptr == PW'(DEPTH - 1)) ? '0 : f_q.wr_ptr + 1'b1;
      end
      if (pop) begin
         f_d.rd_ptr = (f_q.rd_ptr == PW'(DEPTH - 1)) ? '0 : f_q.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         f_d.count = f_q.count + 1'b1;
      end else if (pop && !push) begin
         f_d.count = f_q.count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
   end
endmodule

// *** src/cfg_host_port.sv ***
// Configuration control and shared host port pin logic
`timescale 1ns/1ps
module cfg_host_port
   import cfg_host_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   mem_clear_done,
   input  wire logic                   cfg_complete,
   input  wire logic                   setup_wait_in,
   output logic                        setup_wait_out,
   output logic                        setup_wait_oe,
   input  wire logic [3:0]             mode_sel,
   input  wire logic                   chip_select_low_n,
   input  wire logic                   chip_select_high,
   input  wire logic                   host_transfer_strobe,
   input  wire logic                   host_read_not_write,
   input  wire logic [DATA_W-1:0]      data_in,
   output logic      [STAT_W-1:0]      status_out,
   output logic                        status_oe,
   output logic                        ready_status,
   input  wire logic [HOST_ADDR_W-1:0] host_address_bus,
   input  wire logic                   host_burst_n,
   input  wire logic                   host_beat_in_progress,
   input  wire logic [1:0]             host_transfer_size,
   output logic                        host_transfer_ack,
   output logic      [HOST_ADDR_W-1:0] host_addr_latched,
   output logic      [BYTES_W-1:0]     host_bytes,
   output logic      [MEM_ADDR_W-1:0]  cfg_mem_addr,
   output logic                        cfg_mem_rd_n,
   output logic                        cfg_busy_high_flag,
   output logic                        cfg_busy_low_flag,
   input  wire logic                   user_busy_high,
   input  wire logic                   user_busy_low,
   input  wire logic                   user_setup_wait_out,
   input  wire logic                   user_setup_wait_oe,
   output logic      [3:0]             mode_latched,
   output logic                        cfg_byte_valid,
   output logic      [DATA_W-1:0]      cfg_byte_data,
   input  wire logic                   cfg_byte_ready
);
   typedef struct packed {
      cfg_state_t              state;
      logic [3:0]              mode;
      logic                    sw_prev;
      logic                    busy_hi;
      logic                    busy_lo;
      logic                    sw_out;
      logic                    sw_oe;
      logic [STAT_W-1:0]       stat;
      logic                    stat_oe;
      logic                    rdy;
      logic                    ack_n;
      logic [HOST_ADDR_W-1:0]  haddr;
      logic [BYTES_W-1:0]      hbytes;
      logic                    burst;
      logic [BEAT_W-1:0]       beat;
      logic                    wr_pend;
      logic [MEM_ADDR_W-1:0]   maddr;
      logic                    mrd_n;
      logic                    push_v;
      logic [DATA_W-1:0]       push_d;
   } port_t;

   port_t p_q;
   port_t p_d;

   logic [1:0] strb_lvl_n;
   logic [1:0] strb_fell;
   logic       fifo_in_ready;
   logic       selected;
   logic       wr_edge;
   logic       rd_low;
   logic       loading;

   // Bit 1 is the write/direction line, bit 0 the read/transfer strobe
   edge_sampler #(
      .W (2)
   ) u_strobes (
      .clk      (clk),
      .rst_b    (rst_b),
      .strobe_n ({host_read_not_write, host_transfer_strobe}),
      .level_n  (strb_lvl_n),
      .fell     (strb_fell)
   );

   byte_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (p_q.push_v),
      .in_data   (p_q.push_d),
      .in_ready  (fifo_in_ready),
      .out_valid (cfg_byte_valid),
      .out_data  (cfg_byte_data),
      .out_ready (cfg_byte_ready)
   );

   assign selected = ~chip_select_low_n & chip_select_high;
   assign loading  = (p_q.state == ST_LOAD);
   assign wr_edge  = strb_fell[1];
   assign rd_low   = ~strb_lvl_n[0] & strb_lvl_n[1];

   function automatic logic [BYTES_W-1:0] size_bytes(input logic [1:0] tsz);
      case (tsz)
         TSZ_BYTE: size_bytes = BYTES_ONE;
         TSZ_HALF: size_bytes = BYTES_TWO;
         TSZ_WORD: size_bytes = BYTES_FOUR;
         default:  size_bytes = BYTES_NONE;
      endcase
   endfunction

   always_comb begin
      p_d = p_q;
      p_d.sw_prev = setup_wait_in;
      p_d.ack_n   = 1'b1;
      if (p_q.push_v && fifo_in_ready) begin
         p_d.push_v = 1'b0;
      end
      p_d.stat = '0;
      p_d.stat[STAT_READY_BIT] = fifo_in_ready && !p_q.push_v;
      p_d.stat[STAT_LOAD_BIT]  = loading;
      p_d.stat[STAT_FULL_BIT]  = !fifo_in_ready;
      p_d.stat[STAT_SEL_BIT]   = selected;
      p_d.stat[STAT_BURST_BIT] = p_q.burst;
      p_d.rdy = fifo_in_ready && !p_q.push_v;

      case (p_q.state)
         ST_CLEAR: begin
            p_d.busy_hi = 1'b1;
            p_d.busy_lo = 1'b0;
            p_d.sw_out  = 1'b0;
            p_d.sw_oe   = 1'b1;
            if (mem_clear_done) begin
               p_d.sw_oe = 1'b0;
               p_d.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            p_d.sw_oe = 1'b0;
            if (setup_wait_in && !p_q.sw_prev) begin
               p_d.mode  = mode_sel;
               p_d.state = ST_LOAD;
               p_d.maddr = MEM_ADDR_FIRST;
            end
         end
         ST_LOAD: begin
            p_d.busy_hi = 1'b1;
            p_d.busy_lo = 1'b0;
            p_d.stat_oe = 1'b0;
            case (p_q.mode)
               MODE_ASYNC_PERIPH, MODE_SLAVE_PAR: begin
                  if (selected && wr_edge && !p_q.push_v) begin
                     p_d.push_v = 1'b1;
                     p_d.push_d = data_in;
                  end
                  if (p_q.mode == MODE_ASYNC_PERIPH && selected && rd_low) begin
                     p_d.stat_oe = 1'b1;
                  end
               end
               MODE_PROC: begin
                  if (selected && strb_fell[0]) begin
                     p_d.haddr  = host_address_bus;
                     p_d.hbytes = size_bytes(host_transfer_size);
                     p_d.burst  = ~host_burst_n;
                     p_d.beat   = '0;
                     if (host_read_not_write) begin
                        p_d.stat_oe = 1'b1;
                        p_d.ack_n   = 1'b0;
                     end else begin
                        p_d.wr_pend = 1'b1;
                     end
                  end else if (p_q.burst && !host_beat_in_progress) begin
                     p_d.burst   = 1'b0;
                     p_d.wr_pend = 1'b0;
                  end else if (p_q.burst && p_q.ack_n == 1'b0) begin
                     if (p_q.beat == BURST_LAST_BEAT) begin
                        p_d.burst = 1'b0;
                     end else begin
                        p_d.beat = p_q.beat + 1'b1;
                        if (host_read_not_write) begin
                           p_d.stat_oe = 1'b1;
                           p_d.ack_n   = 1'b0;
                        end else begin
                           p_d.wr_pend = 1'b1;
                        end
                     end
                  end
                  if (p_q.wr_pend && p_d.wr_pend && !p_q.push_v) begin
                     p_d.push_v  = 1'b1;
                     p_d.push_d  = data_in;
                     p_d.wr_pend = 1'b0;
                     p_d.ack_n   = 1'b0;
                  end
               end
               MODE_MASTER_PAR: begin
                  if (p_q.mrd_n) begin
                     if (!p_q.push_v && p_q.maddr != MEM_ADDR_LAST) begin
                        p_d.mrd_n = 1'b0;
                     end
                  end else begin
                     p_d.mrd_n  = 1'b1;
                     p_d.push_v = 1'b1;
                     p_d.push_d = data_in;
                     p_d.maddr  = p_q.maddr + 1'b1;
                  end
               end
               default: begin
                  p_d.stat_oe = 1'b0;
               end
            endcase
            if (cfg_complete) begin
               p_d.state   = ST_DONE;
               p_d.stat_oe = 1'b0;
               p_d.mrd_n   = 1'b1;
               p_d.burst   = 1'b0;
               p_d.wr_pend = 1'b0;
            end
         end
         ST_DONE: begin
            p_d.busy_hi = user_busy_high;
            p_d.busy_lo = user_busy_low;
            p_d.sw_out  = user_setup_wait_out;
            p_d.sw_oe   = user_setup_wait_oe;
            p_d.stat_oe = 1'b0;
         end
         default: begin
            p_d.state = ST_CLEAR;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         p_q         <= '0;
         p_q.state   <= ST_CLEAR;
         p_q.busy_hi <= 1'b1;
         p_q.sw_oe   <= 1'b1;
         p_q.ack_n   <= 1'b1;
         p_q.mrd_n   <= 1'b1;
         p_q.maddr   <= MEM_ADDR_FIRST;
      end else begin
         p_q <= p_d;
      end
   end

   assign setup_wait_out     = p_q.sw_out;
   assign setup_wait_oe      = p_q.sw_oe;
   assign status_out         = p_q.stat;
   assign status_oe          = p_q.stat_oe;
   assign ready_status       = p_q.rdy;
   assign host_transfer_ack  = p_q.ack_n;
   assign host_addr_latched  = p_q.haddr;
   assign host_bytes         = p_q.hbytes;
   assign cfg_mem_addr       = p_q.maddr;
   assign cfg_mem_rd_n       = p_q.mrd_n;
   assign cfg_busy_high_flag = p_q.busy_hi;
   assign cfg_busy_low_flag  = p_q.busy_lo;
   assign mode_latched       = p_q.mode;
endmodule

// *** src/edge_sampler.sv ***
// Registers active-low strobes and flags their falling edges
`timescale 1ns/1ps
module edge_sampler
   import cfg_host_pkg::*;
#(
   parameter int W = 2
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] strobe_n,
   output logic      [W-1:0] level_n,
   output logic      [W-1:0] fell
);
   typedef struct packed {
      logic [W-1:0] lvl;
      logic [W-1:0] fell;
   } samp_t;

   samp_t s_q;
   samp_t s_d;

   always_comb begin
      s_d = s_q;
      for (int i = 0; i < W; i++) begin
         s_d.lvl[i]  = strobe_n[i];
         s_d.fell[i] = s_q.lvl[i] & ~strobe_n[i];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_q <= '{lvl: '1, fell: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign level_n = s_q.lvl;
   assign fell    = s_q.fell;
endmodule
